// ==== verilog/dps_pkg.sv ====
// Constants for the serial front end of the digital resistor device.
// Assumes one system clock far faster than the serial clock.
package dps_pkg;

	// ----------------------------------------
	// Frame geometry
	// ----------------------------------------
	localparam int unsigned CNT_W     = 4;     // Bit counter width
	localparam logic [3:0]  BITS_BYTE = 4'h8;  // Short command length
	localparam logic [3:0]  POS_DEC   = 4'h6;  // Bits held once code is in
	localparam logic [3:0]  POS_DATA  = 4'h7;  // First read data slot
	localparam logic [3:0]  POS_LAST  = 4'hF;  // Last bit of long command
	localparam logic [3:0]  POS_SHORT = 4'h7;  // Last bit of short command
	localparam int unsigned LOC_W     = 4;     // Location field width
	localparam int unsigned DAT_W     = 10;    // Write data width
	localparam int unsigned RD_W      = 9;     // Read data bits returned

	// ----------------------------------------
	// Command codes and locations
	// ----------------------------------------
	localparam logic [1:0] CMD_WRITE = 2'h0;
	localparam logic [1:0] CMD_INC   = 2'h1;
	localparam logic [1:0] CMD_DEC   = 2'h2;
	localparam logic [1:0] CMD_READ  = 2'h3;
	localparam logic [3:0] LOC_VOL0  = 4'h0;  // Volatile wiper 0
	localparam logic [3:0] LOC_VOL1  = 4'h1;  // Volatile wiper 1
	localparam logic [3:0] LOC_NV0   = 4'h2;  // Lock control 0 (HV only)
	localparam logic [3:0] LOC_NV1   = 4'h3;  // Lock control 1 (HV only)
	localparam logic [3:0] LOC_WP    = 4'hF;  // Write protect (HV only)

	// Frame states, one-hot
	typedef enum logic [3:0] {
		ST_IDLE = 4'h1,
		ST_CMD  = 4'h2,
		ST_DATA = 4'h4,
		ST_ERR  = 4'h8
	} dps_state_e;

endpackage

// ==== verilog/dps_spi_slave.sv ====
// Serial slave front end: frames 8/16 bit commands, drives status out.
// Assumes memory logic answers rejects and read data on this clock.
`timescale 1ns/1ps
module dps_spi_slave (
	input  wire logic                         clock,
	input  wire logic                         reset_n,
	input  wire logic                         cs_pin_n,
	input  wire logic                         high_voltage_select_level,
	input  wire logic                         sck_pin,
	input  wire logic                         sdi_pin,
	input  wire logic                         shared_serial_io_pin_in,
	input  wire logic                         shared_variant,
	output logic                              sdo_pin,
	output logic                              sdo_pin_oe,
	output logic                              shared_serial_io_pin_out,
	output logic                              shared_serial_io_pin_oe,
	output logic                              pullup_en,
	output logic                              mode_11,
	output logic [dps_pkg::LOC_W-1:0]         req_loc,
	output logic [1:0]                        req_code,
	output logic                              req_hv,
	input  wire logic                         loc_reject,
	input  wire logic [dps_pkg::RD_W-1:0]     rd_data,
	output logic                              cmd_valid,
	output logic [dps_pkg::LOC_W-1:0]         cmd_loc,
	output logic [1:0]                        command_code_field,
	output logic                              cmd_hv,
	output logic [dps_pkg::DAT_W-1:0]         cmd_data,
	output logic                              command_error_bit
);
	import dps_pkg::*;

	// ----------------------------------------
	// Pin synchronisers
	// ----------------------------------------
	logic [4:0]       s1_q;       // First stage, read by s2 only
	logic [4:0]       s2_q;       // Clean copies of the pins
	logic             sck_old_q;  // Previous clean serial clock
	logic             act_old_q;  // Previous select state

	// Every pin passes two flops before any logic sees it
	always_ff @(posedge clock or negedge reset_n) begin
		if (!reset_n) begin
			// Deselected, normal voltage, clock low, shared pin pulled up
			s1_q <= 5'h11;
			s2_q <= 5'h11;
		end else begin
			s1_q <= {cs_pin_n, high_voltage_select_level, sck_pin,
				sdi_pin, shared_serial_io_pin_in};
			s2_q <= s1_q;
		end
	end

	logic cs_n_s, hv_s, sck_s, din;
	logic active, rise, fall, start;
	assign cs_n_s = s2_q[4];
	assign hv_s   = s2_q[3];
	assign sck_s  = s2_q[2];
	// Shared variant takes input from the common pin
	assign din    = shared_variant ? s2_q[0] : s2_q[1];
	// High-voltage select counts as selected too
	assign active = !cs_n_s || hv_s;
	assign rise   = active && sck_s && !sck_old_q;
	assign fall   = active && !sck_s && sck_old_q;
	assign start  = active && !act_old_q;

	// Edge detect history
	always_ff @(posedge clock or negedge reset_n) begin
		if (!reset_n) begin
			sck_old_q <= 1'b0;
			act_old_q <= 1'b0;
		end else begin
			sck_old_q <= sck_s;
			act_old_q <= active;
		end
	end

	// ----------------------------------------
	// Frame state and bit counter
	// ----------------------------------------
	dps_state_e        state_q;
	logic [CNT_W-1:0]  cnt_q;      // Bits captured in this command
	logic [15:0]       sh_q;       // Shift register, newest bit at 0
	logic              dec_q;      // Pulse: command low bit captured
	logic              chk_q;      // Pulse: check decoded command
	logic              hv_q;       // Frame began at high voltage
	logic [5:0]        fld_q;      // Location and code, frozen
	logic [RD_W-1:0]   rd_q;       // Read value frozen at decode
	logic              is_read;
	logic              step_bad;
	logic              bad;

	// Frozen copy: the shift register keeps moving under data bits
	assign req_loc  = fld_q[5:2];
	assign req_code = fld_q[1:0];
	assign req_hv   = hv_q;
	assign is_read  = (req_code == CMD_READ);

	// Steps only on volatile wipers, or lock and write protect bits at high voltage
	assign step_bad = (req_code == CMD_INC || req_code == CMD_DEC) &&
		!(req_loc == LOC_VOL0 || req_loc == LOC_VOL1 ||
		(hv_q && (req_loc == LOC_NV0 || req_loc == LOC_NV1 ||
		req_loc == LOC_WP)));
	assign bad = step_bad || loc_reject;

	// Main sequencer; deselect clears everything at once
	always_ff @(posedge clock or negedge reset_n) begin
		if (!reset_n) begin
			state_q <= ST_IDLE;
			cnt_q   <= '0;
			sh_q    <= 16'h0000;
			dec_q   <= 1'b0;
			fld_q   <= 6'h00;
		end else if (!active) begin
			// Outside a frame the bus belongs to others
			state_q <= ST_IDLE;
			cnt_q   <= '0;
			sh_q    <= 16'h0000;
			dec_q   <= 1'b0;
			fld_q   <= 6'h00;
		end else begin
			dec_q <= 1'b0;
			case (state_q)
				ST_IDLE: begin
					state_q <= ST_CMD;
					cnt_q   <= '0;
				end
				ST_CMD, ST_DATA: begin
					if (chk_q && bad) begin
						state_q <= ST_ERR;
					end else if (rise) begin
						sh_q  <= {sh_q[14:0], din};
						cnt_q <= cnt_q + 4'h1;
						dec_q <= (cnt_q == POS_DEC - 4'h1);
						if (cnt_q == POS_DEC - 4'h1) begin
							fld_q <= {sh_q[4:0], din};
						end
						if (cnt_q == POS_SHORT && !is_read &&
							req_code != CMD_WRITE) begin
							cnt_q <= '0;
						end else if (cnt_q == POS_SHORT) begin
							state_q <= ST_DATA;
						end else if (cnt_q == POS_LAST) begin
							state_q <= ST_CMD;
							cnt_q   <= '0;
						end
					end
				end
				ST_ERR: begin
					// Input is dropped until deselect
					state_q <= ST_ERR;
				end
				default: begin
					state_q <= ST_IDLE;
				end
			endcase
		end
	end

	// Check pulse, read data capture, frame voltage and mode
	always_ff @(posedge clock or negedge reset_n) begin
		if (!reset_n) begin
			chk_q   <= 1'b0;
			rd_q    <= '0;
			hv_q    <= 1'b0;
			mode_11 <= 1'b0;
		end else begin
			chk_q <= dec_q;
			if (dec_q) begin
				rd_q <= rd_data;
			end
			if (start) begin
				hv_q    <= hv_s;
				mode_11 <= sck_s;
			end
		end
	end

	// ----------------------------------------
	// Command hand-off to memory logic
	// ----------------------------------------
	// Issued only on the last rise of a complete, clean command
	always_ff @(posedge clock or negedge reset_n) begin
		if (!reset_n) begin
			cmd_valid          <= 1'b0;
			cmd_loc            <= '0;
			command_code_field <= 2'h0;
			cmd_hv             <= 1'b0;
			cmd_data           <= '0;
		end else begin
			cmd_valid <= 1'b0;
			if (active && rise && !(chk_q && bad) &&
				(state_q == ST_CMD || state_q == ST_DATA)) begin
				if (cnt_q == POS_SHORT && !is_read &&
					req_code != CMD_WRITE) begin
					cmd_valid          <= 1'b1;
					cmd_loc            <= sh_q[6:3];
					command_code_field <= sh_q[2:1];
					cmd_hv             <= hv_q;
					cmd_data           <= '0;
				end else if (cnt_q == POS_LAST) begin
					cmd_valid          <= 1'b1;
					cmd_loc            <= sh_q[14:11];
					command_code_field <= sh_q[10:9];
					cmd_hv             <= hv_q;
					cmd_data           <= {sh_q[8:0], din};
				end
			end
		end
	end

	// ----------------------------------------
	// Serial output
	// ----------------------------------------
	logic drive_q;   // Shared pin driving window
	logic err_bit;

	assign err_bit = (state_q == ST_ERR) ? 1'b0 : 1'b1;

	// Output bit moves only on falls; select forces idle ones
	always_ff @(posedge clock or negedge reset_n) begin
		if (!reset_n) begin
			sdo_pin <= 1'b1;
			drive_q <= 1'b0;
		end else if (!active || start) begin
			sdo_pin <= 1'b1;
			drive_q <= 1'b0;
		end else if (fall) begin
			if (state_q == ST_ERR) begin
				sdo_pin <= 1'b0;
				drive_q <= 1'b1;
			end else if (cnt_q < POS_DEC) begin
				sdo_pin <= 1'b1;
				drive_q <= 1'b0;
			end else if (cnt_q == POS_DEC) begin
				sdo_pin <= err_bit;
				drive_q <= 1'b1;
			end else if (is_read && cnt_q >= POS_DATA) begin
				sdo_pin <= rd_q[4'(POS_LAST - cnt_q)];
				drive_q <= 1'b1;
			end else begin
				sdo_pin <= 1'b1;
				drive_q <= 1'b0;
			end
		end
	end

	// Dedicated output driven for the whole frame
	assign sdo_pin_oe = active;
	// Open drain: only ever pulls low, so high voltage input survives
	assign shared_serial_io_pin_out = 1'b0;
	assign shared_serial_io_pin_oe  =
		shared_variant && drive_q && !sdo_pin;
	// Pull-up kept on whenever the shared pin is an output
	assign pullup_en = !(shared_variant && active) || drive_q;
	assign command_error_bit = (state_q == ST_ERR);

	// ----------------------------------------
	// Checks
	// ----------------------------------------
	sequence s_sel;
		$rose(active);
	endsequence
	sequence s_sel_idle;
		(state_q == ST_IDLE) ##1 (state_q == ST_CMD && cnt_q == '0 && sdo_pin);
	endsequence

	cnt_clear_a: assert property (@(posedge clock) disable iff (!reset_n)
		s_sel |-> s_sel_idle)
		else $error("counter not cleared at select");
	desel_reset_a: assert property (@(posedge clock) disable iff (!reset_n)
		$fell(active) |=> state_q == ST_IDLE && cnt_q == '0 && !drive_q)
		else $error("deselect did not reset");
	capture_a: assert property (@(posedge clock) disable iff (!reset_n)
		rise && state_q == ST_CMD && !chk_q |=> sh_q[0] == $past(din))
		else $error("input bit not captured on rise");
	out_edge_a: assert property (@(posedge clock) disable iff (!reset_n)
		active && $past(active) && !$past(start) && $changed(sdo_pin)
		|-> $past(fall))
		else $error("output moved off a falling edge");
	ones_first_a: assert property (@(posedge clock) disable iff (!reset_n)
		fall && state_q == ST_CMD && cnt_q < POS_DEC |=> sdo_pin)
		else $error("leading output bits not ones");
	err_low_a: assert property (@(posedge clock) disable iff (!reset_n)
		state_q == ST_ERR && fall |=> !sdo_pin [*2] or !active)
		else $error("error bit not held low");
	err_quiet_a: assert property (@(posedge clock) disable iff (!reset_n)
		state_q == ST_ERR |=> !cmd_valid)
		else $error("command issued in error state");
	step_vol_a: assert property (@(posedge clock) disable iff (!reset_n)
		cmd_valid && !cmd_hv && (command_code_field == CMD_INC ||
		command_code_field == CMD_DEC) |-> cmd_loc < LOC_NV0)
		else $error("step issued on non-volatile location");
	pullup_a: assert property (@(posedge clock) disable iff (!reset_n)
		shared_serial_io_pin_oe |-> pullup_en && !shared_serial_io_pin_out)
		else $error("pull-up off while shared pin drives");
	length_a: assert property (@(posedge clock) disable iff (!reset_n)
		cmd_valid |-> $past(cnt_q) == POS_SHORT || $past(cnt_q) == POS_LAST)
		else $error("command issued at wrong bit count");

endmodule

// ==== sim/dps_host_model.sv ====
// Host side model: drives select, serial clock and data lines.
// Assumes the bench calls its tasks just after clock edges.
`timescale 1ns/1ps
module dps_host_model (
	input  wire logic clock,
	input  wire logic sdo_pin,
	input  wire logic pull_low,
	input  wire logic shr,
	output logic      cs_pin_n,
	output logic      hv_level,
	output logic      sck_pin,
	output logic      sdi_pin,
	output logic      share_wire
);
	localparam int HALF = 8; // 64 ns half period, well under 10 MHz
	logic drive_q; // Host owns the shared wire
	logic mode_q;  // Idle clock level
	// Wired-and with pull-up; a released wire reads high
	assign share_wire = (drive_q ? sdi_pin : 1'b1) & ~pull_low;
	initial begin
		cs_pin_n = 1'b1;
		hv_level = 1'b0;
		sck_pin = 1'b0;
		sdi_pin = 1'b1;
		drive_q = 1'b0;
		mode_q = 1'b0;
	end
	// Data line wanders while not framed, so stale bits never help
	always @(posedge clock) begin
		if (cs_pin_n && !hv_level) begin
			sdi_pin <= ~sdi_pin;
		end
	end
	task automatic tick(input int n);
		repeat (n) @(posedge clock);
	endtask
	// Frame start: idle level first, then setup before any edge
	task automatic sel(input logic mode, input logic hv);
		mode_q = mode;
		sck_pin <= mode;
		tick(HALF);
		cs_pin_n <= hv;
		hv_level <= hv;
		drive_q <= 1'b1;
		tick(HALF);
	endtask
	// Data set on fall, reply sampled just before rise, MSB first
	task automatic shift(input logic [15:0] d, input int n,
		input logic rel, output logic [15:0] got);
		got = 16'hFFFF;
		for (int i = 0; i < n; i++) begin
			sck_pin <= 1'b0;
			sdi_pin <= d[15-i];
			if (rel && i == 6) begin
				drive_q <= 1'b0;
			end
			tick(HALF);
			got[15-i] = shr ? share_wire : sdo_pin;
			sck_pin <= 1'b1;
			tick(HALF);
		end
	endtask
	task automatic desel();
		sck_pin <= mode_q;
		tick(HALF);
		cs_pin_n <= 1'b1;
		hv_level <= 1'b0;
		drive_q <= 1'b0;
		tick(HALF); // Gap before the next select
	endtask
	// Clocking meant for some other device on the bus
	task automatic noise(input int n);
		repeat (n) begin
			sck_pin <= ~sck_pin;
			tick(HALF);
		end
	endtask
endmodule

// ==== sim/digipot_spi_slave_interface_tb.sv ====
// Bench for the serial slave front end: corner and random frames.
// Assumes the package, design and host model are compiled first.
`timescale 1ns/1ps
module digipot_spi_slave_interface_tb;
	import dps_pkg::*;
	logic             clock, reset_n, cs_n, hv, sck, sdi, share, shr;
	logic             loc_reject, sdo, sdo_oe, sh_out, sh_oe, pu, m11;
	logic             cmd_valid, cmd_hv, err_bit, req_hv;
	bit               pu_bad; // Pull-up seen off while pin drives
	logic [RD_W-1:0]  rd_data;
	logic [LOC_W-1:0] cmd_loc, req_loc;
	logic [1:0]       cmd_code, req_code;
	logic [DAT_W-1:0] cmd_data;
	logic [16:0]      last; // Fields of the latest clean command
	int               bad_count, check_count, pulses;

	initial clock = 1'b0;
	always #4 clock = ~clock;

	dps_spi_slave i_dut (.clock(clock), .reset_n(reset_n), .cs_pin_n(cs_n),
		.high_voltage_select_level(hv), .sck_pin(sck), .sdi_pin(sdi),
		.shared_serial_io_pin_in(share), .shared_variant(shr),
		.sdo_pin(sdo), .sdo_pin_oe(sdo_oe), .shared_serial_io_pin_out(sh_out),
		.shared_serial_io_pin_oe(sh_oe), .pullup_en(pu), .mode_11(m11),
		.req_loc(req_loc), .req_code(req_code), .req_hv(req_hv),
		.loc_reject(loc_reject),
		.rd_data(rd_data), .cmd_valid(cmd_valid), .cmd_loc(cmd_loc),
		.command_code_field(cmd_code), .cmd_hv(cmd_hv), .cmd_data(cmd_data),
		.command_error_bit(err_bit));
	dps_host_model i_host (.clock(clock), .sdo_pin(sdo), .pull_low(sh_oe),
		.shr(shr), .cs_pin_n(cs_n), .hv_level(hv), .sck_pin(sck),
		.sdi_pin(sdi), .share_wire(share));

	// Count command pulses; flag pull-up off while the pin drives
	always @(posedge clock) begin
		if (cmd_valid === 1'b1) begin
			pulses <= pulses + 1;
			last <= {cmd_hv, cmd_loc, cmd_code, cmd_data};
		end
		if (sh_oe === 1'b1 && pu !== 1'b1) pu_bad <= 1'b1;
	end

	task automatic check(string what, logic [31:0] seen, logic [31:0] exp);
		check_count++;
		if (seen !== exp) begin
			bad_count++;
			$display("MISMATCH %s expected %h seen %h", what, exp, seen);
		end
	endtask
	task automatic close_out();
		$display("checks %0d mismatches %0d", check_count, bad_count);
		if (bad_count == 0 && check_count > 0)
			$display("SIMULATION PASSED");
		else
			$display("SIMULATION FAILED");
		$finish;
	endtask
	// Refused frame: rejected location, or a step outside the step set
	function automatic logic want_err(logic [15:0] d, logic h, logic rej);
		logic [3:0] l;
		l = d[15:12];
		if (rej) return 1'b1;
		if (d[11:10] == CMD_INC || d[11:10] == CMD_DEC)
			return !(l <= LOC_VOL1 ||
				(h && (l == LOC_NV0 || l == LOC_NV1 || l == LOC_WP)));
		return 1'b0;
	endfunction
	// Ones, then error flag, then read data or ones; low after error
	function automatic logic [15:0] exp_out(logic [15:0] d, int n,
		logic e, logic [8:0] rd, logic s);
		logic [15:0] x;
		x = 16'hFFFF;
		// Shared pin: host hears its own bits until it lets go
		if (s) x[15:10] = d[15:10];
		if (e) x[9:0] = 10'h000;
		else if (d[11:10] == CMD_READ) x[8:0] = rd;
		if (n == 8) x[7:0] = 8'hFF;
		return x;
	endfunction
	// One framed command: reply, request and error compared, pulses and fields for non-reads
	task automatic run(input logic [15:0] d, input int n, input logic mode,
		input logic h, input logic rej, input logic s);
		logic [15:0] got;
		logic        e;
		int          n0;
		e = want_err(d, h, rej);
		n0 = pulses;
		loc_reject <= rej;
		shr <= s;
		rd_data <= 9'($urandom);
		i_host.sel(mode, h);
		check("mode", m11, mode);
		check("drive", sdo_oe, 1);
		i_host.shift(d, n, s && d[11:10] == CMD_READ, got);
		check("request", {req_hv, req_loc, req_code}, {h, d[15:10]});
		check("error", err_bit, e);
		i_host.desel();
		check("reply", got, exp_out(d, n, e, rd_data, s));
		if (d[11:10] != CMD_READ)
			check("pulses", pulses - n0, !e);
		if (!e && d[11:10] != CMD_READ)
			check("fields", last, {h, d[15:10], n == 16 ? d[9:0] : 10'h0});
		check("idle", {sdo_oe, err_bit, sdo}, 3'b001);
	endtask

	// ----------------------------------------
	// Main sequence
	// ----------------------------------------
	initial begin
		logic [15:0] d;
		logic [15:0] got;
		int          n0;
		reset_n = 1'b0;
		loc_reject = 1'b0;
		shr = 1'b0;
		rd_data = '0;
		last = '0;
		void'($urandom(32'h3385));
		repeat (2) @(posedge clock);
		reset_n <= 1'b1;
		repeat (4) @(posedge clock);
		run(16'h03FF, 16, 1'b0, 1'b0, 1'b0, 1'b0);
		run(16'h1C00, 16, 1'b1, 1'b0, 1'b0, 1'b0);
		run(16'h1400, 8, 1'b0, 1'b0, 1'b0, 1'b0);
		run(16'h0800, 8, 1'b1, 1'b0, 1'b0, 1'b0);
		run(16'h2400, 8, 1'b0, 1'b0, 1'b0, 1'b0);
		run(16'h2800, 8, 1'b0, 1'b1, 1'b0, 1'b0);
		run(16'hF400, 8, 1'b1, 1'b1, 1'b0, 1'b0);
		run(16'h6155, 16, 1'b0, 1'b0, 1'b1, 1'b0);
		run(16'h0C00, 16, 1'b0, 1'b0, 1'b0, 1'b1);
		run(16'h1C00, 16, 1'b1, 1'b0, 1'b1, 1'b1);
		for (int k = 0; k < 24; k++) begin
			d = 16'($urandom);
			run(d, (d[11] ^ d[10]) ? 8 : 16, 1'($urandom), 1'($urandom),
				($urandom % 5) == 0, d[11:10] == CMD_READ && 1'($urandom));
		end
		// Short command then long one in one select
		loc_reject <= 1'b0;
		shr <= 1'b0;
		n0 = pulses;
		i_host.sel(1'b0, 1'b0);
		i_host.shift(16'h1400, 8, 1'b0, got);
		i_host.shift(16'h02AA, 16, 1'b0, got);
		i_host.desel();
		check("pair", pulses - n0, 2);
		check("last", last, {1'b0, 16'h02AA});
		// Partial frame, then traffic for another device
		n0 = pulses;
		i_host.sel(1'b0, 1'b0);
		i_host.shift(16'h03FF, 5, 1'b0, got);
		i_host.desel();
		i_host.noise(32);
		check("drop", pulses - n0, 0);
		check("quiet", {sdo_oe, sh_out, sh_oe}, 3'b000);
		check("pullup", pu_bad, 0);
		close_out();
	end

	// Hang guard, about seven times the expected run
	initial begin
		repeat (60000) @(posedge clock);
		bad_count++;
		close_out();
	end
endmodule
